// *** design/bit_timing_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Configuration toward the bit timer and bit events back from it
interface bit_timing_if;
    logic run;
    logic clkSrcSel;
    logic [7:0] prescale;
    logic tqTick;
    logic rxFall;

    modport ctrl (
        output run, clkSrcSel, prescale,
        input tqTick, rxFall
    );
    modport timer (
        input run, clkSrcSel, prescale,
        output tqTick, rxFall
    );
endinterface
`default_nettype wire

// *** design/can_bit_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module can_bit_timer
    import can_timing_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic oscTick,
    input wire logic pllTick,
    input wire logic canRx,
    bit_timing_if.timer bt
);

    // ****************************************************************
    // Quantum generation
    // ****************************************************************
    logic [7:0] preCnt_q, preCnt_d;
    logic srcTick, tqTick;
    logic rxPrev_q;
    logic fallEdge;

    // Source choice between crystal and PLL strobes
    assign srcTick = bt.clkSrcSel ? pllTick : oscTick;
    assign tqTick = srcTick && (preCnt_q == bt.prescale);
    assign preCnt_d = !bt.run ? 8'h00 : (tqTick ? 8'h00 : preCnt_q + 8'h01);
    // Recessive to dominant edge is the resync trigger
    assign fallEdge = rxPrev_q && !canRx;
    // Quantum strobe and resync trigger go to the segment sequencer
    assign bt.tqTick = tqTick;
    assign bt.rxFall = fallEdge;

    always_ff @(posedge clock) begin
        if (rst) begin
            preCnt_q <= 8'h00;
            rxPrev_q <= 1'b1;
        end else begin
            if (srcTick || !bt.run) begin
                preCnt_q <= preCnt_d;
            end
            rxPrev_q <= canRx;
        end
    end

endmodule
`default_nettype wire

// *** design/can_timer_link_bit_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
module can_timer_link_bit_timing
    import can_timing_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic oscTick,
    input wire logic pllTick,
    input wire logic canRx,
    input wire logic rxFrameOk,
    input wire logic txFrameOk,
    output logic timerLinkOut,
    output logic sampledBus
);

    // ****************************************************************
    // Bus slave handshake
    // ****************************************************************
    logic ackPhase_q;
    logic accessFirst, accessDone;
    logic hitMcr0, hitMcr1, hitBtr0, hitBtr1, hitStat, hitAny;
    logic wrMcr0, wrMcr1, wrBtr0, wrBtr1;
    logic [31:0] prdata_q, readMux;

    // One wait state: read data is latched then answered next cycle
    assign accessFirst = psel && penable && !ackPhase_q;
    assign accessDone = psel && penable && ackPhase_q;
    assign pready = ackPhase_q;
    assign pslverr = ackPhase_q && !hitAny;
    assign prdata = prdata_q;

    // Address decode
    assign hitMcr0 = paddr == MCR0_ADDR;
    assign hitMcr1 = paddr == MCR1_ADDR;
    assign hitBtr0 = paddr == BTR0_ADDR;
    assign hitBtr1 = paddr == BTR1_ADDR;
    assign hitStat = paddr == STAT_ADDR;
    assign hitAny = hitMcr0 || hitMcr1 || hitBtr0 || hitBtr1 || hitStat;

    always_ff @(posedge clock) begin
        if (rst) begin
            ackPhase_q <= 1'b0;
        end else begin
            ackPhase_q <= accessFirst;
        end
    end

    // ****************************************************************
    // Control and timing registers
    // ****************************************************************
    logic softReset_q, linkEnable_q, clock_source_select_q;
    logic [7:0] prescale_q;
    logic [1:0] sjw_q;
    logic [3:0] first_time_segment_len_q;
    logic [2:0] second_time_segment_len_q;

    // Writes land at the completing edge; MCR1, BTR0 and BTR1 writes drop silently unless locked
    assign wrMcr0 = accessDone && pwrite && hitMcr0;
    assign wrMcr1 = accessDone && pwrite && hitMcr1 && softReset_q;
    assign wrBtr0 = accessDone && pwrite && hitBtr0 && softReset_q;
    assign wrBtr1 = accessDone && pwrite && hitBtr1 && softReset_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            softReset_q <= SOFT_RESET_RST;
            linkEnable_q <= TLINK_EN_RST;
        end else if (wrMcr0) begin
            softReset_q <= pwdata[SOFT_RESET_BIT];
            linkEnable_q <= pwdata[TLINK_EN_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clock_source_select_q <= CLK_SRC_RST;
        end else if (wrMcr1) begin
            clock_source_select_q <= pwdata[CLK_SRC_BIT];
        end
    end

    // No range checks here; conformity is left to software
    always_ff @(posedge clock) begin
        if (rst) begin
            prescale_q <= PRESCALE_RST;
            sjw_q <= SJW_RST;
        end else if (wrBtr0) begin
            prescale_q <= pwdata[PRESCALE_LSB +: 8];
            sjw_q <= pwdata[SJW_LSB +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            first_time_segment_len_q <= FIRST_TIME_SEGMENT_LEN_RST;
            second_time_segment_len_q <= SECOND_TIME_SEGMENT_LEN_RST;
        end else if (wrBtr1) begin
            first_time_segment_len_q <= pwdata[FIRST_TIME_SEGMENT_LEN_LSB +: 4];
            second_time_segment_len_q <= pwdata[SECOND_TIME_SEGMENT_LEN_LSB +: 3];
        end
    end

    // ****************************************************************
    // Bit timer
    // ****************************************************************
    bit_timing_if bt ();

    // Timer is held idle while the soft-reset lock is on
    assign bt.run = !softReset_q;
    assign bt.clkSrcSel = clock_source_select_q;
    assign bt.prescale = prescale_q;

    can_bit_timer timer (
        .clock(clock),
        .rst(rst),
        .oscTick(oscTick),
        .pllTick(pllTick),
        .canRx(canRx),
        .bt(bt)
    );

    // ****************************************************************
    // Segment sequencing with resync
    // ****************************************************************
    seg_state_t state_q, state_d;
    logic tqTick, fallEdge;
    logic bitStart, sampledBit;
    logic [4:0] tqCnt_q, tqCnt_d;
    logic [4:0] ext_q, ext_d;
    logic resynced_q, resynced_d;
    logic [4:0] seg1Len, seg2Len, sjwLen, remain2;
    logic startNow, sampleNow;

    // Strobes from the bit timer: quantum tick and receive falling edge
    assign tqTick = bt.tqTick;
    assign fallEdge = bt.rxFall;
    // Fields hold length minus one
    assign seg1Len = {1'h0, first_time_segment_len_q} + 5'h1 + ext_q;
    assign seg2Len = {2'h0, second_time_segment_len_q} + 5'h1;
    assign sjwLen = {3'h0, sjw_q} + 5'h1;
    assign remain2 = seg2Len - tqCnt_q;

    // One resync per bit; a late edge stretches segment 1, an early one trims segment 2
    always_comb begin
        state_d = state_q;
        tqCnt_d = tqCnt_q;
        ext_d = ext_q;
        resynced_d = resynced_q;
        startNow = 1'b0;
        sampleNow = 1'b0;
        if (!bt.run) begin
            state_d = SEG_SYNC;
            tqCnt_d = 5'h0;
            ext_d = 5'h0;
            resynced_d = 1'b0;
        end else if (fallEdge && !resynced_q && state_q == SEG_TWO && remain2 <= sjwLen) begin
            // Early edge within reach: it becomes the new sync point
            state_d = SEG_ONE;
            tqCnt_d = 5'h0;
            ext_d = 5'h0;
            resynced_d = 1'b1;
            startNow = 1'b1;
        end else begin
            if (fallEdge && !resynced_q && state_q == SEG_ONE) begin
                // Late edge lengthens segment 1 by at most the jump width
                ext_d = (tqCnt_q + 5'h1 < sjwLen) ? tqCnt_q + 5'h1 : sjwLen;
                resynced_d = 1'b1;
            end else if (fallEdge && !resynced_q && state_q == SEG_TWO) begin
                tqCnt_d = tqCnt_q + sjwLen;
                resynced_d = 1'b1;
            end
            if (tqTick) begin
                case (state_q)
                    SEG_SYNC: begin
                        // One quantum only
                        state_d = SEG_ONE;
                        tqCnt_d = 5'h0;
                    end
                    SEG_ONE: begin
                        if (tqCnt_q + 5'h1 >= seg1Len) begin
                            state_d = SEG_TWO;
                            tqCnt_d = 5'h0;
                            sampleNow = 1'b1;
                        end else begin
                            tqCnt_d = tqCnt_q + 5'h1;
                        end
                    end
                    SEG_TWO: begin
                        if (tqCnt_d + 5'h1 >= seg2Len) begin
                            state_d = SEG_SYNC;
                            tqCnt_d = 5'h0;
                            ext_d = 5'h0;
                            resynced_d = 1'b0;
                            startNow = 1'b1;
                        end else begin
                            tqCnt_d = tqCnt_d + 5'h1;
                        end
                    end
                    default: begin
                        state_d = SEG_SYNC;
                        tqCnt_d = 5'h0;
                    end
                endcase
            end
        end
    end

    // Segment state flops
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= SEG_SYNC;
            tqCnt_q <= 5'h0;
            ext_q <= 5'h0;
            resynced_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tqCnt_q <= tqCnt_d;
            ext_q <= ext_d;
            resynced_q <= resynced_d;
        end
    end

    // Bit events; the sampled level holds while the timer is idle
    always_ff @(posedge clock) begin
        if (rst) begin
            bitStart <= 1'b0;
            sampledBit <= 1'b1;
        end else begin
            bitStart <= startNow;
            if (sampleNow) begin
                sampledBit <= canRx;
            end
        end
    end

    // ****************************************************************
    // Timer link pulse
    // ****************************************************************
    logic pending_q, pulse_q, linkOut_q;
    logic frameEvent;
    logic [7:0] frameCount_q;

    // Receive engine sees own frames, so both sources count
    assign frameEvent = rxFrameOk || txFrameOk;

    // Event waits for the next bit boundary; set beats clear
    always_ff @(posedge clock) begin
        if (rst || !bt.run) begin
            pending_q <= 1'b0;
        end else if (frameEvent) begin
            pending_q <= 1'b1;
        end else if (bitStart) begin
            pending_q <= 1'b0;
        end
    end

    // Pulse runs from one bit start to the next: one bit time
    always_ff @(posedge clock) begin
        if (rst || !bt.run) begin
            pulse_q <= 1'b0;
        end else if (bitStart) begin
            // Only the pending flag feeds it, so a late event is not pulsed twice
            pulse_q <= pending_q;
        end
    end

    // Gate toward the timer capture channel
    always_ff @(posedge clock) begin
        if (rst) begin
            linkOut_q <= 1'b0;
        end else begin
            linkOut_q <= pulse_q && linkEnable_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            frameCount_q <= 8'h00;
        end else if (frameEvent) begin
            frameCount_q <= frameCount_q + 8'h01;
        end
    end

    assign timerLinkOut = linkOut_q;
    assign sampledBus = sampledBit;

    // ****************************************************************
    // Read back
    // ****************************************************************
    always_comb begin
        readMux = 32'h0000_0000;
        if (hitMcr0) begin
            readMux[SOFT_RESET_BIT] = softReset_q;
            readMux[TLINK_EN_BIT] = linkEnable_q;
        end else if (hitMcr1) begin
            readMux[CLK_SRC_BIT] = clock_source_select_q;
        end else if (hitBtr0) begin
            readMux[PRESCALE_LSB +: 8] = prescale_q;
            readMux[SJW_LSB +: 2] = sjw_q;
        end else if (hitBtr1) begin
            readMux[FIRST_TIME_SEGMENT_LEN_LSB +: 4] = first_time_segment_len_q;
            readMux[SECOND_TIME_SEGMENT_LEN_LSB +: 3] = second_time_segment_len_q;
        end else if (hitStat) begin
            readMux[STAT_PULSE_BIT] = pulse_q;
            readMux[STAT_BUS_BIT] = sampledBit;
            readMux[STAT_PEND_BIT] = pending_q;
            readMux[STAT_LOCK_BIT] = softReset_q;
            readMux[STAT_COUNT_LSB +: 8] = frameCount_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (accessFirst) begin
            prdata_q <= pwrite ? 32'h0000_0000 : readMux;
        end
    end

endmodule
`default_nettype wire

// *** design/can_timing_pkg.sv ***
package can_timing_pkg;

    // ****************************************************************
    // Register map (byte addresses, one 32-bit word each)
    // ****************************************************************
    localparam logic [7:0] MCR0_ADDR = 8'h00;
    localparam logic [7:0] MCR1_ADDR = 8'h04;
    localparam logic [7:0] BTR0_ADDR = 8'h08;
    localparam logic [7:0] BTR1_ADDR = 8'h0c;
    localparam logic [7:0] STAT_ADDR = 8'h10;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SOFT_RESET_BIT = 0;
    localparam int TLINK_EN_BIT = 1;
    localparam int CLK_SRC_BIT = 0;
    localparam int PRESCALE_LSB = 0;
    localparam int SJW_LSB = 8;
    localparam int FIRST_TIME_SEGMENT_LEN_LSB = 0;
    localparam int SECOND_TIME_SEGMENT_LEN_LSB = 4;
    localparam int STAT_PULSE_BIT = 0;
    localparam int STAT_BUS_BIT = 1;
    localparam int STAT_PEND_BIT = 2;
    localparam int STAT_LOCK_BIT = 3;
    localparam int STAT_COUNT_LSB = 8;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic SOFT_RESET_RST = 1'b1;
    localparam logic TLINK_EN_RST = 1'b0;
    localparam logic CLK_SRC_RST = 1'b0;
    localparam logic [7:0] PRESCALE_RST = 8'h00;
    localparam logic [1:0] SJW_RST = 2'h0;
    localparam logic [3:0] FIRST_TIME_SEGMENT_LEN_RST = 4'h3;
    localparam logic [2:0] SECOND_TIME_SEGMENT_LEN_RST = 3'h1;

    // Bit time state
    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_ONE,
        SEG_TWO
    } seg_state_t;

endpackage

// *** verif/can_node_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [15:0] bitLen,
    output logic canRx,
    output logic frameDone
);
    // ****************************************************************
    // Remote node: dominant start, recessive tail, then frame accepted
    // ****************************************************************
    // Idle bus rests recessive, as the bus termination pulls it there
    initial begin
        canRx = 1'b1;
        frameDone = 1'b0;
        forever begin
            @(posedge clock);
            if (go) begin
                canRx <= 1'b0;
                repeat (3 * bitLen) @(posedge clock);
                canRx <= 1'b1;
                repeat (10 * bitLen) @(posedge clock);
                frameDone <= 1'b1;
                @(posedge clock);
                frameDone <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/can_timer_link_bit_timing_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module can_timer_link_bit_timing_assertions
    import can_timing_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxFrameOk,
    input wire logic txFrameOk,
    input wire logic timerLinkOut,
    input wire logic sampledBus
);
    // ****************************************************************
    // Shadow of control bits and pulse counters
    // ****************************************************************
    logic linkEn_q, lock_q;
    logic [9:0] sinceEv_q, hiCnt_q;
    wire wrCtl = psel && penable && pready && pwrite && paddr == MCR0_ADDR;
    // Control shadow follows completed writes only
    always_ff @(posedge clock) begin
        if (rst) begin
            linkEn_q <= TLINK_EN_RST;
            lock_q <= SOFT_RESET_RST;
        end else if (wrCtl) begin
            linkEn_q <= pwdata[TLINK_EN_BIT];
            lock_q <= pwdata[SOFT_RESET_BIT];
        end
    end
    // Saturating age of last frame event, length of current pulse
    always_ff @(posedge clock) begin
        if (rst || rxFrameOk || txFrameOk) begin
            sinceEv_q <= rst ? 10'h3ff : 10'h000;
        end else if (sinceEv_q != 10'h3ff) begin
            sinceEv_q <= sinceEv_q + 10'h001;
        end
        hiCnt_q <= (rst || !timerLinkOut) ? 10'h000 : hiCnt_q + 10'h001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_one_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("answer not after one wait state");
    property p_err; pready |-> pslverr == (paddr > STAT_ADDR || paddr[1:0] != 2'h0);
    endproperty
    a_err: assert property (p_err)
        else $error("error flag does not match address");
    property p_off_low; (!linkEn_q)[*3] |-> !timerLinkOut; endproperty
    a_off_low: assert property (p_off_low)
        else $error("link output high while disabled");
    property p_lock_low; lock_q[*3] |-> !timerLinkOut && $stable(sampledBus); endproperty
    a_lock_low: assert property (p_lock_low)
        else $error("bit timer active while locked");
    property p_rx_soon; rxFrameOk && linkEn_q && !lock_q |-> ##[1:210] timerLinkOut;
    endproperty
    a_rx_soon: assert property (p_rx_soon)
        else $error("no link pulse after received frame");
    property p_tx_soon; txFrameOk && linkEn_q && !lock_q |-> ##[1:210] timerLinkOut;
    endproperty
    a_tx_soon: assert property (p_tx_soon)
        else $error("no link pulse after own frame");
    property p_cause; $rose(timerLinkOut) |-> sinceEv_q <= 10'h0d2; endproperty
    a_cause: assert property (p_cause)
        else $error("link pulse without a frame event");
    property p_width_max; timerLinkOut |-> hiCnt_q < 10'h0c8; endproperty
    a_width_max: assert property (p_width_max)
        else $error("link pulse longer than longest bit");
    property p_width_min; $fell(timerLinkOut) |-> hiCnt_q >= 10'h007; endproperty
    a_width_min: assert property (p_width_min)
        else $error("link pulse shorter than shortest bit");
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module testbench;
    import can_timing_pkg::*;
    logic clock, rst, psel, penable, pwrite, oscTick, pllTick, txFrameOk, go, busSeen;
    logic pready, pslverr, canRx, rxFrameOk, timerLinkOut, sampledBus;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdQ[$];
    logic [15:0] bitLen, hi, wQ[$];
    logic bQ[$];
    logic [16:0] r;
    logic [1:0] p, sj;
    logic [3:0] s1;
    logic [2:0] s2;
    int errTotal, nCompared;
    can_timer_link_bit_timing i_can_timer_link_bit_timing (.clock, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oscTick,
        .pllTick, .canRx, .rxFrameOk, .txFrameOk, .timerLinkOut, .sampledBus);
    can_node_model i_can_node_model (.clock, .go, .bitLen, .canRx, .frameDone(rxFrameOk));
    // ****************************************************************
    // Clock, strobes and bus tasks
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Second quantum source strobes every other cycle, doubling the bit
    always @(posedge clock) pllTick <= ~pllTick;
    function automatic logic [16:0] nextLfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pulseTx;
        txFrameOk <= 1'b1;
        @(posedge clock);
        txFrameOk <= 1'b0;
    endtask
    task automatic finalReport;
        // Notes never matched mean a result that never came
        errTotal += wQ.size() + bQ.size() + rdQ.size();
        if (errTotal == 0 && nCompared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watcher: every result that shows up is matched to the oldest note
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite) `CHK(prdata, rdQ.pop_front())
        if (timerLinkOut === 1'b1) hi <= hi + 16'h1;
        else if (hi != 16'h0) begin
            `CHK(hi, wQ.pop_front())
            hi <= 16'h0;
        end
        if (!rst && sampledBus !== busSeen) begin
            `CHK(sampledBus, bQ.pop_front())
            busSeen <= sampledBus;
        end
    end
    // Hang guard, long enough for every frame at the slowest bit
    initial begin
        repeat (60000) @(posedge clock);
        errTotal++;
        finalReport;
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, txFrameOk, go, pllTick} = 6'h00;
        {paddr, pwdata, hi, bitLen} = 72'h0;
        {oscTick, rst, busSeen} = 3'h7;
        r = 17'h10cee;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd(MCR0_ADDR, 32'h1);
        rd(BTR0_ADDR, 32'h0);
        rd(BTR1_ADDR, {25'h0, SECOND_TIME_SEGMENT_LEN_RST, FIRST_TIME_SEGMENT_LEN_RST});
        rd(STAT_ADDR, 32'ha);
        rd(8'h14, 32'h0);
        // Unlocked: configuration writes must bounce, link output stays low
        apb(1'b1, MCR0_ADDR, 32'h0);
        apb(1'b1, BTR1_ADDR, 32'h7f);
        apb(1'b1, MCR1_ADDR, 32'h1);
        rd(BTR1_ADDR, {25'h0, SECOND_TIME_SEGMENT_LEN_RST, FIRST_TIME_SEGMENT_LEN_RST});
        rd(MCR1_ADDR, 32'h0);
        pulseTx;
        repeat (300) @(posedge clock);
        // Boundary settings first, then random ones; odd passes use the PLL strobe
        for (int i = 0; i < 6; i++) begin
            r = nextLfsr(r);
            p = (i == 1) ? 2'h3 : (i == 0) ? 2'h0 : r[1:0];
            s1 = (i == 1) ? 4'hf : (i == 0 || r[5:2] < 4'h3) ? 4'h3 : r[5:2];
            s2 = (i == 1) ? 3'h7 : (i == 0 || r[8:6] == 3'h0) ? 3'h1 : r[8:6];
            sj = 2'(i + 2);
            sj = (3'(sj) > s2) ? s2[1:0] : sj;
            bitLen = 16'((p + 1) * (3 + s1 + s2) * (i[0] ? 2 : 1));
            apb(1'b1, MCR0_ADDR, 32'h1);
            apb(1'b1, MCR1_ADDR, {r[16:0], 14'h0, i[0]});
            apb(1'b1, BTR0_ADDR, {r[16:0], 5'h0, sj, 6'h0, p});
            apb(1'b1, BTR1_ADDR, {r[15:0], 9'h0, s2, s1});
            rd(MCR1_ADDR, {31'h0, i[0]});
            rd(BTR0_ADDR, {22'h0, sj, 6'h0, p});
            rd(BTR1_ADDR, {25'h0, s2, s1});
            apb(1'b1, MCR0_ADDR, 32'h2);
            wQ.push_back(bitLen);
            if (i[0]) pulseTx;
            else begin
                bQ.push_back(1'b0);
                bQ.push_back(1'b1);
                go <= 1'b1;
                @(posedge clock);
                go <= 1'b0;
            end
            for (int k = 0; k < 4000 && wQ.size() != 0; k++) @(posedge clock);
        end
        finalReport;
    end
endmodule
bind can_timer_link_bit_timing can_timer_link_bit_timing_assertions
    i_can_timer_link_bit_timing_assertions (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .rxFrameOk, .txFrameOk, .timerLinkOut, .sampledBus);
`default_nettype wire
